// ===== verilog/pmc_pin_mode.sv
// Port 0 media interface and management pin mode control
`timescale 1ns/1ns
module pmc_pin_mode
	import pmc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        refClk,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  portModeStrap,
	input  wire logic        duplexPolarityStrap,
	output logic             refClkOe_n,
	output logic             refClkInEn,
	output logic             refClkPullDown,
	input  wire logic        colIn,
	output logic             colOut,
	output logic             colOe_n,
	input  wire logic        crsIn,
	output logic             crsOut,
	output logic             crsOe_n,
	input  wire logic        phyCol,
	input  wire logic        phyCrs,
	input  wire logic        duplexPin,
	output logic             macCol,
	output logic             macCrs,
	output logic             effDuplex,
	output logic             partnerFullDuplex,
	input  wire logic        mdioIn,
	output logic             mdioOut,
	output logic             mdioOe_n,
	input  wire logic        mdcIn,
	output logic             mdcOut,
	output logic             mdcOe_n,
	input  wire logic        mgmtDataOut,
	input  wire logic        mgmtDataDrive,
	output logic             mgmtDataIn,
	output logic             mgmtClk,
	output logic             refClkAlive
);
	// ==========================================================
	// Strap capture
	logic [2:0]  modeStrap_r;
	logic        polStrap_r;
	logic        strapHold_r;
	logic [2:0]  modeSync0_r;
	logic [2:0]  modeSync1_r;
	logic [1:0]  polSync_r;
	pmc_mode_t   mode;
	// Straps are pins: two flops before the capture register
	always_ff @(posedge clk) begin
		modeSync0_r <= portModeStrap;
		modeSync1_r <= modeSync0_r;
		polSync_r   <= {polSync_r[0], duplexPolarityStrap};
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strapHold_r <= 1'b0;
		end else begin
			strapHold_r <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!strapHold_r) begin
			modeStrap_r <= modeSync1_r;
			polStrap_r  <= polSync_r[1];
		end
	end
	function automatic pmc_mode_t decodeMode(input logic [2:0] code);
		if (code == MODE_MAC)
			return PMC_MAC;
		else if (code == MODE_PHY)
			return PMC_PHY;
		else if (code == MODE_T200A || code == MODE_T200B)
			return PMC_PHY200;
		else if (code >= MODE_RPHY_A && code <= MODE_RPHY_C)
			return PMC_RPHY;
		else
			return PMC_RSVD;
	endfunction
	assign mode = decodeMode(modeStrap_r);
	// ==========================================================
	// APB control and status
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [31:0] rdata_nxt;
	logic        accessPhase;
	logic        hitCtrl;
	logic        hitStatus;
	logic        pready_r;
	assign accessPhase = psel && penable && !pready_r;
	assign hitCtrl     = paddr == PMC_CTRL_OFS;
	assign hitStatus   = paddr == PMC_STATUS_OFS;
	assign ctrl_nxt    = (accessPhase && pwrite && hitCtrl) ? (pwdata & CTRL_MASK) : ctrl_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r   <= CTRL_RESET;
			pready_r <= 1'b0;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			pready_r <= accessPhase;
			prdata   <= (accessPhase && !pwrite) ? rdata_nxt : 32'h0000_0000;
			pslverr  <= accessPhase && !(hitCtrl || hitStatus);
		end
	end
	assign pready = pready_r;
	// ==========================================================
	// Control bits
	logic isolate;
	logic autoNeg;
	logic clkDirOut;
	logic anDuplex;
	logic mgmtMaster;
	logic phyLike;
	logic miiPhy;
	logic rmii;
	assign isolate    = ctrl_r[CTRL_ISO_BIT];
	assign autoNeg    = ctrl_r[CTRL_AN_BIT];
	assign clkDirOut  = ctrl_r[CTRL_CLKDIR_BIT];
	assign anDuplex   = ctrl_r[CTRL_ANDUP_BIT];
	assign mgmtMaster = ctrl_r[CTRL_MGMST_BIT];
	assign rmii       = mode == PMC_RPHY;
	assign miiPhy     = mode == PMC_PHY || mode == PMC_PHY200;
	assign phyLike    = miiPhy || rmii;
	// ==========================================================
	// Pin synchronisers
	logic [1:0] colSync_r;
	logic [1:0] crsSync_r;
	logic [1:0] dupSync_r;
	logic [1:0] mdioSync_r;
	logic [1:0] mdcSync_r;
	always_ff @(posedge clk) begin
		colSync_r  <= {colSync_r[0], colIn};
		crsSync_r  <= {crsSync_r[0], crsIn};
		dupSync_r  <= {dupSync_r[0], duplexPin};
		mdioSync_r <= {mdioSync_r[0], mdioIn};
		mdcSync_r  <= {mdcSync_r[0], mdcIn};
	end
	// ==========================================================
	// Reference clock domain activity crossing
	logic       refTog_r;
	logic [1:0] refRstSync_r;
	logic [2:0] refTogSync_r;
	logic [3:0] refIdle_r;
	// Reset carried into the link clock domain so the toggle starts known
	always_ff @(posedge refClk) begin
		refRstSync_r <= {refRstSync_r[0], sys_rst};
	end
	// Toggle on link clock shows it runs
	always_ff @(posedge refClk) begin
		if (refRstSync_r[1]) begin
			refTog_r <= 1'b0;
		end else begin
			refTog_r <= !refTog_r;
		end
	end
	always_ff @(posedge clk) begin
		refTogSync_r <= {refTogSync_r[1:0], refTog_r};
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			refIdle_r   <= 4'h0;
			refClkAlive <= 1'b0;
		end else if (refTogSync_r[2] != refTogSync_r[1]) begin
			refIdle_r   <= 4'h0;
			refClkAlive <= rmii && !isolate;
		end else if (refIdle_r != 4'hf) begin
			refIdle_r   <= refIdle_r + 4'h1;
		end else begin
			refClkAlive <= 1'b0;
		end
	end
	// ==========================================================
	// Pin direction and pin function
	logic dupLevel;
	logic mdcDiv_r;
	logic [1:0] mdcCnt_r;
	assign dupLevel = dupSync_r[1] ^ polStrap_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mdcCnt_r <= 2'h0;
			mdcDiv_r <= 1'b0;
		end else begin
			mdcCnt_r <= mdcCnt_r + 2'h1;
			if (mdcCnt_r == 2'(MDC_DIV / 2 - 1))
				mdcDiv_r <= !mdcDiv_r;
		end
	end
	// ==========================================================
	// Next pin controls
	logic refDrive;
	logic refInOn;
	logic miiDrive;
	logic macMode;
	logic effDupNxt;
	assign refDrive  = rmii && clkDirOut;
	assign refInOn   = !refDrive && !isolate;
	assign miiDrive  = miiPhy && !isolate;
	assign macMode   = mode == PMC_MAC;
	assign effDupNxt = (macMode && autoNeg) ? anDuplex : dupLevel;
	// ==========================================================
	// Reference clock pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			refClkOe_n     <= 1'b1;
			refClkInEn     <= 1'b0;
			refClkPullDown <= 1'b0;
		end else begin
			refClkOe_n     <= !(refDrive && !isolate);
			refClkInEn     <= refInOn;
			refClkPullDown <= refInOn;
		end
	end
	// ==========================================================
	// Collision and carrier outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			colOut  <= 1'b0;
			colOe_n <= 1'b1;
			crsOut  <= 1'b0;
			crsOe_n <= 1'b1;
		end else begin
			colOut  <= phyCol;
			colOe_n <= !miiDrive;
			crsOut  <= phyCrs;
			crsOe_n <= !miiDrive;
		end
	end
	// ==========================================================
	// Collision and carrier inputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			macCol <= 1'b0;
			macCrs <= 1'b0;
		end else begin
			// Collision from PHY in MAC mode
			// Carrier from PHY in MAC mode
			macCol <= macMode && colSync_r[1];
			macCrs <= macMode && crsSync_r[1];
		end
	end
	// ==========================================================
	// Duplex
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			effDuplex         <= 1'b0;
			partnerFullDuplex <= 1'b0;
		end else begin
			effDuplex         <= effDupNxt;
			partnerFullDuplex <= phyLike && dupLevel;
		end
	end
	// ==========================================================
	// Management data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mdioOut    <= 1'b0;
			mdioOe_n   <= 1'b1;
			mgmtDataIn <= 1'b1;
		end else begin
			mdioOut    <= mgmtDataOut;
			mdioOe_n   <= !mgmtDataDrive;
			mgmtDataIn <= mdioSync_r[1];
		end
	end
	// ==========================================================
	// Management clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mdcOut  <= 1'b0;
			mdcOe_n <= 1'b1;
			mgmtClk <= 1'b0;
		end else begin
			mdcOut  <= mgmtMaster && mdcDiv_r;
			mdcOe_n <= !mgmtMaster;
			mgmtClk <= mgmtMaster ? mdcDiv_r : mdcSync_r[1];
		end
	end
	// ==========================================================
	// Status read mux
	assign rdata_nxt = hitCtrl ? ctrl_r :
		hitStatus ? {22'h0, refClkAlive, partnerFullDuplex, effDuplex, polStrap_r, 3'(mode), modeStrap_r} :
		32'h0000_0000;
endmodule // pmc_pin_mode

// ===== verilog/pmc_pkg.sv
// Constants and types for the port 0 pin mode control block
package pmc_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] PMC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] PMC_STATUS_OFS = 12'h004;
	// ==========================================================
	// Control register fields
	localparam int CTRL_ISO_BIT   = 0;
	localparam int CTRL_AN_BIT    = 1;
	localparam int CTRL_CLKDIR_BIT = 2;
	localparam int CTRL_ANDUP_BIT = 3;
	localparam int CTRL_MGMST_BIT = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK  = 32'h0000_001f;
	// ==========================================================
	// Strap mode codes
	localparam logic [2:0] MODE_MAC    = 3'h0;
	localparam logic [2:0] MODE_PHY    = 3'h1;
	localparam logic [2:0] MODE_T200A  = 3'h2;
	localparam logic [2:0] MODE_T200B  = 3'h3;
	localparam logic [2:0] MODE_RPHY_A = 3'h4;
	localparam logic [2:0] MODE_RPHY_C = 3'h6;
	localparam logic [2:0] MODE_RSVD   = 3'h7;
	// ==========================================================
	// Timing
	localparam int REF_CLK_MHZ = 50;
	localparam int SYS_CLK_MHZ = 10;
	localparam int MDC_DIV     = 4;
	typedef enum logic [2:0] {PMC_MAC, PMC_PHY, PMC_PHY200, PMC_RPHY, PMC_RSVD} pmc_mode_t;
endpackage

// ===== dv/pmc_pin_mode_props.sv
// Checker for the port 0 pin mode control block
`timescale 1ns/1ns
module pmc_pin_mode_chk
	import pmc_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [2:0] portModeStrap,
	input wire logic       refClkOe_n,
	input wire logic       refClkInEn,
	input wire logic       refClkPullDown,
	input wire logic       colIn,
	input wire logic       colOut,
	input wire logic       colOe_n,
	input wire logic       crsIn,
	input wire logic       crsOut,
	input wire logic       crsOe_n,
	input wire logic       phyCol,
	input wire logic       phyCrs,
	input wire logic       macCol,
	input wire logic       macCrs
);
	logic [2:0] modeQ;
	logic       rphy;
	// Mode as latched while reset is held
	always_ff @(posedge clk)
		if (sys_rst)
			modeQ <= portModeStrap;
	assign rphy = modeQ >= MODE_RPHY_A && modeQ <= MODE_RPHY_C;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Pin checks
	ref_pull_a: assert property (refClkInEn == refClkPullDown)
		else $error("ref buffer and pull-down differ");
	ref_drive_a: assert property (!refClkOe_n |-> !refClkInEn && !refClkPullDown)
		else $error("ref input on while driving");
	ref_dir_a: assert property (!rphy |-> refClkOe_n)
		else $error("ref driven outside reduced mode");
	col_drive_a: assert property (!colOe_n |-> colOut == $past(phyCol))
		else $error("collision out wrong");
	crs_drive_a: assert property (!crsOe_n |-> crsOut == $past(phyCrs))
		else $error("carrier out wrong");
	rmii_unused_a: assert property (rphy |-> colOe_n && crsOe_n)
		else $error("unused pin driven");
	mac_col_a: assert property (modeQ == MODE_MAC |-> macCol == $past(colIn, 3))
		else $error("collision in wrong");
	mac_crs_a: assert property (modeQ == MODE_MAC |-> macCrs == $past(crsIn, 3))
		else $error("carrier in wrong");
	mac_only_a: assert property (modeQ != MODE_MAC |-> !macCol && !macCrs)
		else $error("mac inputs seen outside mac mode");
endmodule // pmc_pin_mode_chk
bind pmc_pin_mode pmc_pin_mode_chk u_chk (.clk, .sys_rst, .portModeStrap, .refClkOe_n, .refClkInEn,
	.refClkPullDown, .colIn, .colOut, .colOe_n, .crsIn, .crsOut, .crsOe_n, .phyCol, .phyCrs, .macCol, .macCrs);

// ===== dv/pmc_far_end.sv
// Far-end MAC or PHY model on the port 0 media pins
`timescale 1ns/1ns
module pmc_far_end (
	input  wire logic clkRun,
	input  wire logic refClkOe_n,
	input  wire logic colReq,
	input  wire logic crsReq,
	input  wire logic colOut,
	input  wire logic colOe_n,
	input  wire logic crsOut,
	input  wire logic crsOe_n,
	output logic      refClk,
	output logic      colIn,
	output logic      crsIn
);
	logic tog = 1'b0;
	initial begin
		#13;
		forever #40 tog = ~tog;
	end
	assign refClk = clkRun && refClkOe_n && tog;
	assign colIn = colOe_n ? colReq : colOut;
	assign crsIn = crsOe_n ? crsReq : crsOut;
endmodule // pmc_far_end

// ===== dv/testbench.sv
// Testbench for the port 0 pin mode control block
`timescale 1ns/1ns
module testbench
	import pmc_pkg::*;
;
	logic        clk, sys_rst, psel, penable, pwrite, pslverr, pready, refClk, er, colReq, crsReq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  portModeStrap, e;
	logic        duplexPolarityStrap, refClkOe_n, refClkInEn, refClkPullDown, colIn, colOut, colOe_n;
	logic        crsIn, crsOut, crsOe_n, phyCol, phyCrs, duplexPin, macCol, macCrs, effDuplex, clkRun;
	logic        partnerFullDuplex, mdioOut, mdioOe_n, mdcOut, mdcOe_n, mgmtDataOut, mdioExt, mdcExt;
	logic        mgmtDataDrive, mgmtDataIn, mgmtClk, refClkAlive;
	int          fail_count, tests_run;
	logic [31:0] cv[4] = '{32'h4, 32'h5, 32'h1, 32'h0};
	logic [2:0]  ex[4] = '{3'h0, 3'h4, 3'h4, 3'h7};
	wire         mdioIn = mdioOe_n ? mdioExt : mdioOut;
	wire         mdcIn = mdcOe_n ? mdcExt : mdcOut;
	pmc_pin_mode DUT (.clk, .sys_rst, .refClk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .portModeStrap, .duplexPolarityStrap, .refClkOe_n, .refClkInEn, .refClkPullDown, .colIn,
		.colOut, .colOe_n, .crsIn, .crsOut, .crsOe_n, .phyCol, .phyCrs, .duplexPin, .macCol, .macCrs,
		.effDuplex, .partnerFullDuplex, .mdioIn, .mdioOut, .mdioOe_n, .mdcIn, .mdcOut, .mdcOe_n,
		.mgmtDataOut, .mgmtDataDrive, .mgmtDataIn, .mgmtClk, .refClkAlive);
	pmc_far_end u_far (.clkRun, .refClkOe_n, .colReq, .crsReq, .colOut, .colOe_n, .crsOut, .crsOe_n,
		.refClk, .colIn, .crsIn);
	// ==========================================================
	// Tasks
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rst(input logic [2:0] m, input logic p);
		portModeStrap <= m;
		duplexPolarityStrap <= p;
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wrap_up();
		$display("Checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#300000;
		fail_count++;
		wrap_up();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, phyCol, phyCrs, duplexPin, mgmtDataOut, mgmtDataDrive} = '0;
		{mdcExt, colReq, crsReq, clkRun, portModeStrap, duplexPolarityStrap, tests_run, fail_count} = '0;
		mdioExt = 1'b1;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		chk({refClkOe_n, colOe_n, crsOe_n, mdioOe_n, mdcOe_n, mgmtDataIn, pready}, 7'h7e);
		for (int m = 0; m < 8; m++) begin
			e = (m == 7) ? 3'h4 : (m > 3) ? 3'h3 : (m > 1) ? 3'h2 : m[2:0];
			rst(m[2:0], 1'b0);
			portModeStrap <= ~m[2:0];
			bus(1'b0, PMC_STATUS_OFS, 32'h0);
			chk(rd[5:0], {e, m[2:0]});
			chk({colOe_n, crsOe_n, refClkOe_n}, {m < 1 || m > 3, m < 1 || m > 3, 1'b1});
		end
		rst(3'h0, 1'b0);
		colReq <= 1'b1;
		crsReq <= 1'b1;
		duplexPin <= 1'b1;
		repeat (5) @(posedge clk);
		chk({macCol, macCrs, effDuplex}, 3'h7);
		bus(1'b1, PMC_CTRL_OFS, 32'h2);
		repeat (2) @(posedge clk);
		chk(effDuplex, 1'b0);
		colReq <= 1'b0;
		crsReq <= 1'b0;
		rst(3'h0, 1'b1);
		chk(effDuplex, 1'b0);
		rst(3'h1, 1'b0);
		phyCol <= 1'b1;
		phyCrs <= 1'b1;
		repeat (2) @(posedge clk);
		chk({colOut, crsOut, colOe_n, crsOe_n, partnerFullDuplex}, 5'h19);
		bus(1'b1, PMC_CTRL_OFS, 32'h11);
		mgmtDataDrive <= 1'b1;
		mgmtDataOut <= 1'b1;
		repeat (2) @(posedge clk);
		chk({colOe_n, crsOe_n, mdcOe_n, mdioOe_n}, 4'hc);
		chk(mdioOut, 1'b1);
		bus(1'b1, PMC_CTRL_OFS, 32'h0);
		mgmtDataDrive <= 1'b0;
		mdioExt <= 1'b0;
		mdcExt <= 1'b1;
		repeat (5) @(posedge clk);
		chk({mdcOe_n, mdioOe_n, mgmtDataIn, mgmtClk}, 4'hd);
		clkRun <= 1'b1;
		rst(3'h4, 1'b0);
		foreach (cv[i]) begin
			bus(1'b1, PMC_CTRL_OFS, cv[i]);
			repeat (2) @(posedge clk);
			chk({refClkOe_n, refClkInEn, refClkPullDown}, ex[i]);
		end
		bus(1'b0, PMC_STATUS_OFS, 32'h0);
		chk(rd[9], 1'b1);
		bus(1'b0, 12'h010, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		clkRun <= 1'b0;
		wrap_up();
	end
endmodule // testbench
